/* File: hcc_pkg.sv */
// Constants shared by both ends of the hub configuration link.
// Assumes a single 125 MHz core clock on both ends.
package hcc_pkg;
	// Link addressing and vendor request framing
	localparam logic [6:0]  SMB_ADDR   = 7'h2c;
	localparam logic [7:0]  VR_TYPE    = 8'h40;
	localparam logic [7:0]  VR_CODE    = 8'he3;
	localparam logic [15:0] VR_LEN     = 16'h0000;
	localparam logic [15:0] SEL_VID    = 16'h0001;
	localparam logic [15:0] SEL_PID    = 16'h0002;
	localparam logic [15:0] SEL_PORT   = 16'h0004;
	localparam logic [15:0] SEL_UPDATE = 16'h0008;
	localparam logic [15:0] SEL_JK12   = 16'h0020;
	localparam logic [15:0] SEL_JK34   = 16'h0080;
	// Device configuration register addresses (command codes)
	localparam logic [7:0]  RA_VID_LO  = 8'h00;
	localparam logic [7:0]  RA_VID_HI  = 8'h01;
	localparam logic [7:0]  RA_PID_LO  = 8'h02;
	localparam logic [7:0]  RA_PID_HI  = 8'h03;
	localparam logic [7:0]  RA_ELEC    = 8'h04;
	localparam logic [7:0]  RA_PORT    = 8'h05;
	localparam logic [7:0]  RA_JK12    = 8'h07;
	localparam logic [7:0]  RA_JK34    = 8'h08;
	// Values after reset
	localparam logic [5:0]  RST_PORT   = 6'h30;
	localparam logic [7:0]  RST_ELEC   = 8'h40;
	localparam logic [2:0]  RST_JK     = 3'h2;
	// Timing
	localparam int CLK_NS      = 8;
	localparam int RECONN_NS   = 10000;
	localparam int RECONN_CYC  = (RECONN_NS + CLK_NS - 1) / CLK_NS;
	localparam int SMB_KHZ     = 100;
	localparam int SMB_QTR_CYC = (1000000 + SMB_KHZ * 4 * CLK_NS - 1) / (SMB_KHZ * 4 * CLK_NS);
	// Host command port offsets and fields
	localparam logic [3:0]  HR_GO      = 4'h0;
	localparam logic [3:0]  HR_ARG0    = 4'h4;
	localparam logic [3:0]  HR_ARG1    = 4'h8;
	localparam logic [3:0]  HR_STAT    = 4'hc;
	localparam int          ST_BUSY    = 0;
	localparam int          ST_NACK    = 1;
	localparam int          ST_RBYTE   = 8;
	typedef enum logic [1:0] {OP_NONE = 2'b00, OP_SMB_WR = 2'b01, OP_SMB_RD = 2'b10, OP_VREQ = 2'b11} hcc_op_e;
	typedef enum logic [2:0] {DS_IDLE = 3'b000, DS_ADDR = 3'b001, DS_CMD = 3'b010, DS_WDATA = 3'b011,
		DS_RDATA = 3'b100, DS_DONE = 3'b101} hcc_sph_e;
	typedef enum logic [2:0] {HS_IDLE = 3'b000, HS_START = 3'b001, HS_BYTE = 3'b010, HS_STOP = 3'b011,
		HS_VREQ = 3'b100} hcc_hst_e;
endpackage : hcc_pkg

/* File: hcc_link_if.sv */
// Link between the configuration host and the hub device: SMBus pins and vendor requests.
// Open-drain lines are resolved here from each end's output enable.
`timescale 1ns/1ps
interface hcc_link_if;
	logic        h_scl_o;
	logic        h_scl_oe;
	logic        h_sda_o;
	logic        h_sda_oe;
	logic        d_sda_o;
	logic        d_sda_oe;
	logic        scl;
	logic        sda;
	logic        vr_valid;
	logic [7:0]  vr_type;
	logic [7:0]  vr_code;
	logic [15:0] vr_value;
	logic [15:0] vr_index;
	logic [15:0] vr_len;
	logic        vr_done;
	// Wired-AND with pull-up
	assign scl = ~(h_scl_oe & ~h_scl_o);
	assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
	modport dev (input scl, sda, vr_valid, vr_type, vr_code, vr_value, vr_index, vr_len,
		output d_sda_o, d_sda_oe, vr_done);
	modport host (input scl, sda, vr_done,
		output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, vr_valid, vr_type, vr_code, vr_value, vr_index, vr_len);
endinterface : hcc_link_if

/* File: hcc_dev.sv */
// Hub configuration front end: SMBus slave plus vendor request decoder.
// Assumes SMBus pins and the reset pin are asynchronous; vendor requests share clk.
// How it works
// - Write byte: address, command, data, all acknowledged
// - Receiver pulls line low to acknowledge
// - Read byte: command, repeated start, one byte
// - Master sends no stop before repeated start
// - Master NACKs read byte; device releases line
// - Vendor request type 40, code E3, length 0
// - Selector 1 stores vendor id internally only
// - Selector 2 stores product id internally only
// - Host sends update request to report changes
// - Update request disconnects, reconnects upstream port
// - Selector 4 stores port setup and tuning
// - Port setup bits 3:0 mark non-removable ports
// - Port setup bits 5:4 give port count
// - Tuning bits 4:0 select enhanced slew rate
// - Tuning bits 7:5 upstream JK, default 010
// - Selector 20 sets ports 1, 2 JK
// - Selector 80 sets ports 3, 4 JK
// - Downstream JK changes apply without update
// - Slave address 2C; command selects register
// - SMBus active only while reset pin asserted
// - Eight-bit bytes, MSB first, then acknowledge
`timescale 1ns/1ps
module hcc_dev
	import hcc_pkg::*;
#(
	parameter logic [15:0] VID_DEF = 16'h1a2b, // arbitrary value
	parameter logic [15:0] PID_DEF = 16'h3c4d, // arbitrary value
	parameter int          RECONN  = hcc_pkg::RECONN_CYC
) (
	hcc_link_if.dev            lk,
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          ext_rst_n,
	output logic [15:0]        rep_vid,
	output logic [15:0]        rep_pid,
	output logic [5:0]         rep_port_setup,
	output logic [3:0]         port_en,
	output logic [4:0]         slew_sel,
	output logic [2:0]         us_jk,
	output logic [11:0]        ds_jk,
	output logic               upstream_attach
);
	import hcc_pkg::*;

	logic [1:0]  scl_s;
	logic [1:0]  sda_s;
	logic [1:0]  rst_s;
	logic        scl_d;
	logic        sda_d;
	logic        scl;
	logic        sda;
	logic        smb_en;
	logic        rise;
	logic        fall;
	logic        start;
	logic        stop;
	hcc_sph_e    ph_r;
	logic [3:0]  cnt_r;
	logic [6:0]  sh_r;
	logic [7:0]  cmd_r;
	logic [7:0]  tx_r;
	logic        ack_r;
	logic        rw_r;
	logic        drv_r;
	logic        zero_r;
	logic [7:0]  byte_in;
	logic        smb_wr;
	logic        vr_ok;
	logic        vr_done_r;
	logic [15:0] vid_r;
	logic [15:0] pid_r;
	logic [5:0]  port_r;
	logic [7:0]  elec_r;
	logic [11:0] jk_r;
	logic [15:0] rc_r;
	logic        attach_r;

	// Two-stage synchronisers; the third stage only feeds edge detection
	always_ff @(posedge clk) begin
		if (srst) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			rst_s <= 2'h0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], lk.scl};
			sda_s <= {sda_s[0], lk.sda};
			rst_s <= {rst_s[0], ext_rst_n};
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
		end
	end

	assign scl     = scl_s[1];
	assign sda     = sda_s[1];
	assign smb_en  = ~rst_s[1];
	assign rise    = scl & ~scl_d;
	assign fall    = ~scl & scl_d;
	assign start   = scl & scl_d & sda_d & ~sda;
	assign stop    = scl & scl_d & ~sda_d & sda;
	assign byte_in = {sh_r, sda};
	assign smb_wr  = smb_en && rise && cnt_r == 4'h7 && ph_r == DS_WDATA;

	// Register image as seen on the SMBus; reserved bits read zero
	function automatic logic [7:0] rd_reg(input logic [7:0] a);
		case (a)
			RA_VID_LO: rd_reg = vid_r[7:0];
			RA_VID_HI: rd_reg = vid_r[15:8];
			RA_PID_LO: rd_reg = pid_r[7:0];
			RA_PID_HI: rd_reg = pid_r[15:8];
			RA_ELEC:   rd_reg = elec_r;
			RA_PORT:   rd_reg = {2'h0, port_r};
			RA_JK12:   rd_reg = {jk_r[5:3], 1'b0, jk_r[2:0], 1'b0};
			RA_JK34:   rd_reg = {jk_r[11:9], 1'b0, jk_r[8:6], 1'b0};
			default:   rd_reg = 8'h00;
		endcase
	endfunction : rd_reg

	// SMBus slave byte engine; bits taken on SCL rise, line changed on SCL fall
	always_ff @(posedge clk) begin
		if (srst || !smb_en) begin
			ph_r  <= DS_IDLE;
			cnt_r <= 4'h0;
			sh_r  <= 7'h00;
			cmd_r <= 8'h00;
			tx_r  <= 8'h00;
			ack_r <= 1'b0;
			rw_r  <= 1'b0;
			drv_r <= 1'b0;
		end else if (start) begin
			ph_r  <= DS_ADDR;
			cnt_r <= 4'h0;
			drv_r <= 1'b0;
		end else if (stop) begin
			ph_r  <= DS_IDLE;
			drv_r <= 1'b0;
		end else if (ph_r != DS_IDLE) begin
			if (rise && ph_r != DS_DONE) begin
				if (cnt_r != 4'h8) begin
					sh_r  <= byte_in[6:0];
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'h7) begin
						case (ph_r)
							DS_ADDR: begin
								ack_r <= byte_in[7:1] == SMB_ADDR;
								rw_r  <= byte_in[0];
								tx_r  <= rd_reg(cmd_r);
							end
							DS_CMD: begin
								ack_r <= 1'b1;
								cmd_r <= byte_in;
							end
							DS_WDATA: ack_r <= 1'b1;
							default:  ack_r <= 1'b0;
						endcase
					end
				end else begin
					cnt_r <= 4'h0;
					case (ph_r)
						DS_ADDR:  ph_r <= !ack_r ? DS_DONE : (rw_r ? DS_RDATA : DS_CMD);
						DS_CMD:   ph_r <= DS_WDATA;
						default:  ph_r <= DS_DONE;
					endcase
				end
			end
			// Pull low for ack or a zero data bit, else release
			if (fall) begin
				if (ph_r == DS_RDATA && cnt_r != 4'h8)
					drv_r <= ~tx_r[3'h7 - cnt_r[2:0]];
				else
					drv_r <= cnt_r == 4'h8 && ack_r && ph_r != DS_DONE;
			end
		end
	end

	// Open-drain drive: only ever pulls low
	always_ff @(posedge clk) begin
		if (srst)
			zero_r <= 1'b0;
		else
			zero_r <= 1'b0;
	end
	assign lk.d_sda_o  = zero_r;
	assign lk.d_sda_oe = drv_r;

	// Vendor request framing check
	assign vr_ok = lk.vr_valid && lk.vr_type == VR_TYPE && lk.vr_code == VR_CODE && lk.vr_len == VR_LEN;

	always_ff @(posedge clk) begin
		if (srst)
			vr_done_r <= 1'b0;
		else
			vr_done_r <= lk.vr_valid;
	end
	assign lk.vr_done = vr_done_r;

	// Configuration store; SMBus write wins if both arrive together
	always_ff @(posedge clk) begin
		if (srst) begin
			vid_r  <= VID_DEF;
			pid_r  <= PID_DEF;
			port_r <= RST_PORT;
			elec_r <= RST_ELEC;
			jk_r   <= {4{RST_JK}};
		end else if (smb_wr) begin
			case (cmd_r)
				RA_VID_LO: vid_r[7:0]  <= byte_in;
				RA_VID_HI: vid_r[15:8] <= byte_in;
				RA_PID_LO: pid_r[7:0]  <= byte_in;
				RA_PID_HI: pid_r[15:8] <= byte_in;
				RA_ELEC:   elec_r      <= byte_in;
				RA_PORT:   port_r      <= byte_in[5:0];
				RA_JK12:   jk_r[5:0]   <= {byte_in[7:5], byte_in[3:1]};
				RA_JK34:   jk_r[11:6]  <= {byte_in[7:5], byte_in[3:1]};
				default:   ;
			endcase
		end else if (vr_ok) begin
			case (lk.vr_value)
				SEL_VID:  vid_r <= lk.vr_index;
				SEL_PID:  pid_r <= lk.vr_index;
				SEL_PORT: begin
					port_r <= lk.vr_index[5:0];
					elec_r <= lk.vr_index[15:8];
				end
				SEL_JK12: jk_r[5:0]  <= {lk.vr_index[10:8], lk.vr_index[2:0]};
				SEL_JK34: jk_r[11:6] <= {lk.vr_index[10:8], lk.vr_index[2:0]};
				default:  ;
			endcase
		end
	end

	// Transmitter tuning follows the store directly
	assign slew_sel = elec_r[4:0];
	assign us_jk    = elec_r[7:5];
	assign ds_jk    = jk_r;

	// Upstream reconnect; a new update during a disconnect restarts the count
	always_ff @(posedge clk) begin
		if (srst) begin
			attach_r <= 1'b1;
			rc_r     <= 16'h0000;
		end else if (vr_ok && lk.vr_value == SEL_UPDATE) begin
			attach_r <= 1'b0;
			rc_r     <= 16'(RECONN - 1);
		end else if (!attach_r) begin
			if (rc_r == 16'h0000)
				attach_r <= 1'b1;
			else
				rc_r <= rc_r - 16'h0001;
		end
	end
	assign upstream_attach = attach_r;

	// Reported identity and port setup: refreshed at reattach, or freely while in SMBus mode
	always_ff @(posedge clk) begin
		if (srst) begin
			rep_vid        <= VID_DEF;
			rep_pid        <= PID_DEF;
			rep_port_setup <= RST_PORT;
			port_en        <= 4'hf;
		end else if (smb_en || (!attach_r && rc_r == 16'h0000)) begin
			rep_vid        <= vid_r;
			rep_pid        <= pid_r;
			rep_port_setup <= port_r;
			port_en        <= {port_r[5:4] == 2'h3, port_r[5], |port_r[5:4], 1'b1};
		end
	end
endmodule : hcc_dev

/* File: hcc_host.sv */
// Configuration host: SMBus master and vendor request issuer behind a small register port.
// Assumes the device answers vendor requests on the same clock.
`timescale 1ns/1ps
module hcc_host
	import hcc_pkg::*;
#(
	parameter int QTR = hcc_pkg::SMB_QTR_CYC
) (
	hcc_link_if.host         lk,
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata
);
	import hcc_pkg::*;

	hcc_op_e     op_r;
	hcc_hst_e    hs_r;
	logic [15:0] arg0_r;
	logic [15:0] arg1_r;
	logic        busy_r;
	logic        nack_r;
	logic [7:0]  rbyte_r;
	logic [1:0]  sda_s;
	logic [15:0] qc_r;
	logic        tick;
	logic [1:0]  qp_r;
	logic [2:0]  st_r;
	logic [3:0]  bi_r;
	logic [8:0]  tx_r;
	logic [8:0]  rx_r;
	logic        scl_lo_r;
	logic        sda_lo_r;
	logic        zero_r;
	logic        vr_valid_r;
	logic [10:0] nx;

	// Element list: {kind 0 start 1 byte 2 stop, read-byte flag, byte}
	function automatic logic [10:0] elem(input hcc_op_e op, input logic [2:0] st);
		elem = {2'h2, 1'b0, 8'h00};
		if (op == OP_SMB_WR) begin
			case (st)
				3'h0:    elem = {2'h0, 1'b0, 8'h00};
				3'h1:    elem = {2'h1, 1'b0, SMB_ADDR, 1'b0};
				3'h2:    elem = {2'h1, 1'b0, arg0_r[7:0]};
				3'h3:    elem = {2'h1, 1'b0, arg1_r[7:0]};
				default: elem = {2'h2, 1'b0, 8'h00};
			endcase
		end else begin
			case (st)
				3'h0:    elem = {2'h0, 1'b0, 8'h00};
				3'h1:    elem = {2'h1, 1'b0, SMB_ADDR, 1'b0};
				3'h2:    elem = {2'h1, 1'b0, arg0_r[7:0]};
				3'h3:    elem = {2'h0, 1'b0, 8'h00};
				3'h4:    elem = {2'h1, 1'b0, SMB_ADDR, 1'b1};
				3'h5:    elem = {2'h1, 1'b1, 8'hff};
				default: elem = {2'h2, 1'b0, 8'h00};
			endcase
		end
	endfunction : elem

	assign nx   = elem(op_r, st_r + 3'h1);
	assign tick = qc_r == 16'(QTR - 1);

	// Data line sampled through two flip-flops
	always_ff @(posedge clk) begin
		if (srst)
			sda_s <= 2'h3;
		else
			sda_s <= {sda_s[0], lk.sda};
	end

	// Quarter-bit timer, running only during SMBus traffic
	always_ff @(posedge clk) begin
		if (srst || hs_r == HS_IDLE || hs_r == HS_VREQ || tick)
			qc_r <= 16'h0000;
		else
			qc_r <= qc_r + 16'h0001;
	end

	// Command port writes and the transfer sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			op_r       <= OP_NONE;
			hs_r       <= HS_IDLE;
			arg0_r     <= 16'h0000;
			arg1_r     <= 16'h0000;
			busy_r     <= 1'b0;
			nack_r     <= 1'b0;
			rbyte_r    <= 8'h00;
			qp_r       <= 2'h0;
			st_r       <= 3'h0;
			bi_r       <= 4'h0;
			tx_r       <= 9'h1ff;
			rx_r       <= 9'h000;
			scl_lo_r   <= 1'b0;
			sda_lo_r   <= 1'b0;
			vr_valid_r <= 1'b0;
		end else begin
			vr_valid_r <= 1'b0;
			if (wr && !busy_r && addr == HR_ARG0)
				arg0_r <= wdata[15:0];
			if (wr && !busy_r && addr == HR_ARG1)
				arg1_r <= wdata[15:0];
			// Go is refused while busy
			if (wr && !busy_r && addr == HR_GO && hcc_op_e'(wdata[1:0]) != OP_NONE) begin
				op_r   <= hcc_op_e'(wdata[1:0]);
				busy_r <= 1'b1;
				nack_r <= 1'b0;
				st_r   <= 3'h0;
				qp_r   <= 2'h0;
				if (hcc_op_e'(wdata[1:0]) == OP_VREQ) begin
					hs_r       <= HS_VREQ;
					vr_valid_r <= 1'b1;
				end else
					hs_r <= HS_START;
			end
			case (hs_r)
				HS_VREQ: if (lk.vr_done) begin
					hs_r   <= HS_IDLE;
					busy_r <= 1'b0;
				end
				HS_START, HS_BYTE, HS_STOP: if (tick) begin
					qp_r <= qp_r + 2'h1;
					case ({hs_r == HS_STOP, hs_r == HS_BYTE, qp_r})
						// Start: release data, raise clock, pull data, pull clock
						4'b00_00: sda_lo_r <= 1'b0;
						4'b00_01: scl_lo_r <= 1'b0;
						4'b00_10: sda_lo_r <= 1'b1;
						// Byte bit: set data with clock low, sample in high half
						4'b01_00: sda_lo_r <= ~tx_r[8];
						4'b01_01: scl_lo_r <= 1'b0;
						4'b01_10: rx_r <= {rx_r[7:0], sda_s[1]};
						4'b01_11: begin
							scl_lo_r <= 1'b1;
							tx_r     <= {tx_r[7:0], 1'b1};
							bi_r     <= bi_r + 4'h1;
						end
						// Stop: data low, clock high, data high
						4'b10_00: sda_lo_r <= 1'b1;
						4'b10_01: scl_lo_r <= 1'b0;
						4'b10_10: sda_lo_r <= 1'b0;
						default: ;
					endcase
					if (qp_r == 2'h3 && hs_r == HS_START)
						scl_lo_r <= 1'b1;
					// Element finished: move to the next one
					if (qp_r == 2'h3 && (hs_r != HS_BYTE || bi_r == 4'h8)) begin
						st_r <= st_r + 3'h1;
						bi_r <= 4'h0;
						if (hs_r == HS_STOP) begin
							hs_r   <= HS_IDLE;
							busy_r <= 1'b0;
						end else if (hs_r == HS_BYTE && elem(op_r, st_r) == {2'h1, 1'b1, 8'hff}) begin
							rbyte_r <= rx_r[8:1];
							hs_r    <= HS_STOP;
						end else if (hs_r == HS_BYTE && rx_r[0]) begin
							nack_r <= 1'b1;
							hs_r   <= HS_STOP;
						end else begin
							hs_r <= nx[10:9] == 2'h0 ? HS_START : (nx[10:9] == 2'h1 ? HS_BYTE : HS_STOP);
							tx_r <= nx[8] ? 9'h1ff : {nx[7:0], 1'b1};
						end
					end
				end
				default: ;
			endcase
			if (hs_r == HS_START && tick && qp_r == 2'h3 && st_r == 3'h0)
				tx_r <= {SMB_ADDR, 1'b0, 1'b1};
		end
	end

	// Read data for one cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst || !rd)
			rdata <= 32'h0000_0000;
		else case (addr)
			HR_GO:   rdata <= {30'h0, op_r};
			HR_ARG0: rdata <= {16'h0, arg0_r};
			HR_ARG1: rdata <= {16'h0, arg1_r};
			HR_STAT: rdata <= {16'h0, rbyte_r, 6'h0, nack_r, busy_r};
			default: rdata <= 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst)
			zero_r <= 1'b0;
		else
			zero_r <= 1'b0;
	end

	assign lk.h_scl_o  = zero_r;
	assign lk.h_scl_oe = scl_lo_r;
	assign lk.h_sda_o  = zero_r;
	assign lk.h_sda_oe = sda_lo_r;
	assign lk.vr_valid = vr_valid_r;
	assign lk.vr_type  = VR_TYPE;
	assign lk.vr_code  = VR_CODE;
	assign lk.vr_len   = VR_LEN;
	assign lk.vr_value = arg0_r;
	assign lk.vr_index = arg1_r;
endmodule : hcc_host

/* File: hcc_link_props.sv */
// Concurrent checks on the link between the configuration host and the hub device.
// Assumes the bench feeds it the interface signals, the core clock and reset.
`timescale 1ns/1ps
module hcc_link_props
	import hcc_pkg::*;
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        scl,
	input wire logic        h_scl_o,
	input wire logic        h_scl_oe,
	input wire logic        h_sda_o,
	input wire logic        h_sda_oe,
	input wire logic        d_sda_o,
	input wire logic        d_sda_oe,
	input wire logic        vr_valid,
	input wire logic [7:0]  vr_type,
	input wire logic [7:0]  vr_code,
	input wire logic [15:0] vr_len,
	input wire logic        vr_done
);
	// Ack plus eight low data bits at the bench bit rate, with margin
	localparam int DRV_MAX = 700;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// Vendor request framing and answer
	vr_done_follow_a: assert property (vr_valid |=> vr_done)
		else $error("vendor request not answered next cycle");
	vr_done_cause_a: assert property (vr_done |-> $past(vr_valid))
		else $error("done without a request");
	vr_frame_a: assert property (vr_valid |-> vr_type == VR_TYPE && vr_code == VR_CODE && vr_len == VR_LEN)
		else $error("bad vendor request framing");
	vr_one_pulse_a: assert property (vr_valid |=> !vr_valid)
		else $error("request not a single pulse");
	// Open-drain ends only ever pull low
	dev_sda_low_a: assert property (d_sda_oe |-> !d_sda_o)
		else $error("device drives data high");
	host_pins_low_a: assert property ((h_sda_oe |-> !h_sda_o) and (h_scl_oe |-> !h_scl_o))
		else $error("host drives a line high");
	// Device data only moves while the clock is low
	dev_sda_hold_a: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
		else $error("device data changed while clock high");
	dev_drive_start_a: assert property ($rose(d_sda_oe) |-> !scl)
		else $error("device started driving while clock high");
	// Device lets go of the data line after at most an ack plus one byte
	dev_release_a: assert property ($rose(d_sda_oe) |-> ##[1:DRV_MAX] !d_sda_oe)
		else $error("device holds data line too long");
endmodule : hcc_link_props

/* File: tb_hub_config_command_interface.sv */
// Self-checking bench: host and hub device joined by the link interface.
// Assumes shortened bit and reconnect times so the run stays short.
`timescale 1ns/1ps
module tb_hub_config_command_interface;
	import hcc_pkg::*;
	localparam logic [15:0] VID_D = 16'h1a2b; // arbitrary value
	localparam logic [15:0] PID_D = 16'h3c4d; // arbitrary value
	typedef struct packed {logic [31:0] exp; logic [31:0] mask;} hcc_note_s;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        ext_rst_n = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        chk_r = 1'b0;
	logic        chk_q = 1'b0;
	logic        probe_r = 1'b0;
	logic        probe_sel = 1'b0;
	logic [31:0] rdata;
	logic [15:0] rep_vid;
	logic [15:0] rep_pid;
	logic [5:0]  rep_port_setup;
	logic [3:0]  port_en;
	logic [4:0]  slew_sel;
	logic [2:0]  us_jk;
	logic [11:0] ds_jk;
	logic        upstream_attach;
	logic [31:0] dev_vec;
	hcc_note_s   notes[$];
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	// Stored and reported configuration as the bench expects it
	logic [15:0] s_vid = VID_D, s_pid = PID_D, r_vid = VID_D, r_pid = PID_D;
	logic [5:0]  s_port = RST_PORT, r_port = RST_PORT;
	logic [7:0]  s_elec = RST_ELEC;
	logic [11:0] s_jk = {4{RST_JK}};

	always #4 clk = ~clk;

	hcc_link_if hcc_link_if_i ();
	hcc_dev #(.VID_DEF(VID_D), .PID_DEF(PID_D), .RECONN(20)) hcc_dev_i (.lk(hcc_link_if_i), .clk(clk),
		.srst(srst), .ext_rst_n(ext_rst_n), .rep_vid(rep_vid), .rep_pid(rep_pid), .rep_port_setup(rep_port_setup),
		.port_en(port_en), .slew_sel(slew_sel), .us_jk(us_jk), .ds_jk(ds_jk), .upstream_attach(upstream_attach));
	hcc_host #(.QTR(16)) hcc_host_i (.lk(hcc_link_if_i), .clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	hcc_link_props hcc_link_props_i (.clk(clk), .srst(srst), .scl(hcc_link_if_i.scl),
		.h_scl_o(hcc_link_if_i.h_scl_o), .h_scl_oe(hcc_link_if_i.h_scl_oe), .h_sda_o(hcc_link_if_i.h_sda_o),
		.h_sda_oe(hcc_link_if_i.h_sda_oe), .d_sda_o(hcc_link_if_i.d_sda_o), .d_sda_oe(hcc_link_if_i.d_sda_oe),
		.vr_valid(hcc_link_if_i.vr_valid), .vr_type(hcc_link_if_i.vr_type), .vr_code(hcc_link_if_i.vr_code),
		.vr_len(hcc_link_if_i.vr_len), .vr_done(hcc_link_if_i.vr_done));

	assign dev_vec = {rep_port_setup, port_en, slew_sel, us_jk, ds_jk, upstream_attach, 1'b0};

	// Port enables from the count field, slew and JK split out of the tuning byte
	function automatic logic [31:0] vec1(input logic [5:0] p, input logic [7:0] e, input logic [11:0] j,
		input logic a);
		vec1 = {p, 4'((5'h2 << p[5:4]) - 5'h1), e[4:0], e[7:5], j, a, 1'b0};
	endfunction : vec1

	function automatic void apply(input logic [7:0] ra, input logic [7:0] d);
		case (ra)
			RA_VID_LO: s_vid[7:0] = d;
			RA_VID_HI: s_vid[15:8] = d;
			RA_PID_LO: s_pid[7:0] = d;
			RA_PID_HI: s_pid[15:8] = d;
			RA_ELEC:   s_elec = d;
			RA_PORT:   s_port = d[5:0];
			RA_JK12:   s_jk[5:0] = {d[7:5], d[3:1]};
			RA_JK34:   s_jk[11:6] = {d[7:5], d[3:1]};
			default:   ;
		endcase
	endfunction : apply

	function automatic logic [7:0] rb(input logic [7:0] ra);
		case (ra)
			RA_VID_LO: rb = s_vid[7:0];
			RA_VID_HI: rb = s_vid[15:8];
			RA_PID_LO: rb = s_pid[7:0];
			RA_PID_HI: rb = s_pid[15:8];
			RA_ELEC:   rb = s_elec;
			RA_PORT:   rb = {2'b00, s_port};
			RA_JK12:   rb = {s_jk[5:3], 1'b0, s_jk[2:0], 1'b0};
			RA_JK34:   rb = {s_jk[11:9], 1'b0, s_jk[8:6], 1'b0};
			default:   rb = 8'h00;
		endcase
	endfunction : rb

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{e, m});
		@(posedge clk);
		addr  <= a;
		rd    <= 1'b1;
		chk_r <= 1'b1;
		@(posedge clk);
		rd    <= 1'b0;
		chk_r <= 1'b0;
	endtask : rd_chk

	task automatic probe(input logic s, input logic [31:0] e);
		notes.push_back('{e, 32'hffffffff});
		@(posedge clk);
		probe_sel <= s;
		probe_r   <= 1'b1;
		@(posedge clk);
		probe_r   <= 1'b0;
	endtask : probe

	// Issue one operation and poll until the host is idle again
	task automatic run_op(input logic [1:0] op, input logic [15:0] a0, input logic [15:0] a1);
		logic busy;
		wr_reg(HR_ARG0, {16'h0, a0});
		wr_reg(HR_ARG1, {16'h0, a1});
		wr_reg(HR_GO, {30'h0, op});
		busy = 1'b1;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
			@(posedge clk);
			addr <= HR_STAT;
			rd   <= 1'b1;
			@(posedge clk);
			rd   <= 1'b0;
			@(posedge clk);
			busy = rdata[ST_BUSY];
		end
		if (busy !== 1'b0) begin
			num_errors++;
			results();
		end
	endtask : run_op

	task automatic results();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	// Result watcher: one note per checked read or probe, oldest first
	always @(posedge clk) begin : watch
		hcc_note_s   n;
		logic [31:0] got;
		chk_q <= chk_r;
		if (chk_q || probe_r) begin
			n = '{32'hdeadbeef, 32'hffffffff}; // Missing note forces a mismatch
			if (notes.size() > 0)
				n = notes.pop_front();
			got = chk_q ? rdata : (probe_sel ? dev_vec : {rep_vid, rep_pid});
			samples_checked++;
			if ((got & n.mask) !== (n.exp & n.mask)) begin
				num_errors++;
				$display("wrong value at %0t: got %h expected %h", $time, got, n.exp);
			end
		end
	end

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			num_errors++;
			results();
		end
	end

	initial begin
		logic [15:0] idx;
		logic [7:0]  d;
		void'($urandom(57));
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		probe(1'b0, {VID_D, PID_D});
		probe(1'b1, vec1(RST_PORT, RST_ELEC, {4{RST_JK}}, 1'b1));
		// Every command code written then read back, unmapped 06 included
		for (int i = 0; i < 9; i++) begin
			d = 8'($urandom());
			run_op(OP_SMB_WR, 16'(i), {8'h0, d});
			rd_chk(HR_STAT, 32'h0, 32'h3);
			rd_chk(HR_ARG1, {24'h0, d}, 32'hffffffff);
			rd_chk(HR_GO, 32'h1, 32'hffffffff);
			apply(8'(i), d);
			run_op(OP_SMB_RD, 16'(i), 16'h0);
			rd_chk(HR_STAT, {16'h0, rb(8'(i)), 8'h0}, 32'h0000ff03);
		end
		r_vid = s_vid;
		r_pid = s_pid;
		r_port = s_port;
		probe(1'b0, {r_vid, r_pid});
		probe(1'b1, vec1(r_port, s_elec, s_jk, 1'b1));
		// Released reset pin: slave no longer answers
		ext_rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		run_op(OP_SMB_WR, {8'h0, RA_VID_LO}, {8'h0, ~s_vid[7:0]});
		rd_chk(HR_STAT, 32'h2, 32'h3);
		// Identity changes stay internal; unknown selector changes nothing
		idx = 16'($urandom());
		run_op(OP_VREQ, SEL_VID, idx);
		s_vid = idx;
		idx = 16'($urandom());
		run_op(OP_VREQ, SEL_PID, idx);
		s_pid = idx;
		run_op(OP_VREQ, 16'h0040, 16'hffff);
		probe(1'b0, {r_vid, r_pid});
		// Downstream JK levels take effect at once
		idx = 16'($urandom());
		run_op(OP_VREQ, SEL_JK12, idx);
		s_jk[5:0] = {idx[10:8], idx[2:0]};
		idx = 16'($urandom());
		run_op(OP_VREQ, SEL_JK34, idx);
		s_jk[11:6] = {idx[10:8], idx[2:0]};
		probe(1'b1, vec1(r_port, s_elec, s_jk, 1'b1));
		// Each port count, reported only after the reconnect
		for (int n = 0; n < 4; n++) begin
			idx = {8'($urandom()), 2'b00, 2'(n), 4'($urandom())};
			run_op(OP_VREQ, SEL_PORT, idx);
			s_port = idx[5:0];
			s_elec = idx[15:8];
			probe(1'b1, vec1(r_port, s_elec, s_jk, 1'b1));
			run_op(OP_VREQ, SEL_UPDATE, 16'h0);
			probe(1'b1, vec1(r_port, s_elec, s_jk, 1'b0));
			repeat (30) @(posedge clk);
			r_port = s_port;
			r_vid = s_vid;
			r_pid = s_pid;
			probe(1'b1, vec1(r_port, s_elec, s_jk, 1'b1));
			probe(1'b0, {r_vid, r_pid});
		end
		repeat (3) @(posedge clk);
		results();
	end
endmodule : tb_hub_config_command_interface
